/* File: vicd_defs.vh */
// Constants of the vectored interrupt command decoder: opcodes, layouts, resets.
// Assumes inclusion by the decoder and its helper modules only.
`ifndef VICD_DEFS_VH
`define VICD_DEFS_VH

// ----------------------------------------------------------------------
// Full-byte commands
// ----------------------------------------------------------------------
`define VICD_CMD_RESET 8'h00

// ----------------------------------------------------------------------
// Five-bit opcodes, command bits 7..3
// ----------------------------------------------------------------------
`define VICD_OP5_CLR_REQ_MSK 5'h02
`define VICD_OP5_CLR_ONE_REQ_MSK 5'h03
`define VICD_OP5_CLR_MSK 5'h04
`define VICD_OP5_CLR_ONE_MSK 5'h05
`define VICD_OP5_SET_MSK 5'h06
`define VICD_OP5_SET_ONE_MSK 5'h07
`define VICD_OP5_CLR_REQ 5'h08
`define VICD_OP5_CLR_ONE_REQ 5'h09
`define VICD_OP5_SET_REQ 5'h0a
`define VICD_OP5_SET_ONE_REQ 5'h0b
`define VICD_OP5_CLR_SRV 5'h0e
`define VICD_OP5_CLR_ONE_SRV 5'h0f

// ----------------------------------------------------------------------
// Four-bit opcodes, command bits 7..4
// ----------------------------------------------------------------------
`define VICD_OP4_CLR_TOP_SRV 4'h6
`define VICD_OP4_MODE_LOW_A 4'h8
`define VICD_OP4_MODE_LOW_B 4'h9
`define VICD_OP4_MODE_HIGH 4'ha
`define VICD_OP4_WSEL_MASK 4'hb
`define VICD_OP4_WSEL_ACLR 4'hc

// ----------------------------------------------------------------------
// Operating options bit positions and reset value
// ----------------------------------------------------------------------
`define VICD_M_ROT 0
`define VICD_M_COMMON 1
`define VICD_M_POLLED 2
`define VICD_M_OUTPOL 3
`define VICD_M_INPOL 4
`define VICD_M_RDLO 5
`define VICD_M_RDHI 6
`define VICD_M_ARM 7
`define VICD_MODE_RST 8'h20

// ----------------------------------------------------------------------
// Arm control field, read select codes, write target codes
// ----------------------------------------------------------------------
`define VICD_ARM_KEEP 2'h0
`define VICD_ARM_SET 2'h1
`define VICD_ARM_CLR 2'h2
`define VICD_RD_REQ 2'h0
`define VICD_RD_SRV 2'h1
`define VICD_RD_MSK 2'h2
`define VICD_RD_ACLR 2'h3
`define VICD_WT_NONE 2'h0
`define VICD_WT_MASK 2'h1
`define VICD_WT_ACLR 2'h2

// ----------------------------------------------------------------------
// Register reset values and the common-mode acknowledge vector
// ----------------------------------------------------------------------
`define VICD_MASK_RST 8'hff
`define VICD_ZERO8 8'h00
`define VICD_ONES8 8'hff
`define VICD_COMMON_VEC 3'h7

`endif

/* File: vicd_sync.v */
// Two-stage synchroniser for the bus request lines.
// Assumes asynchronous pins; the first stage feeds only the second.
`timescale 1ns/1ps
module vicd_sync #(
  parameter W = 8
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] pin,
  output wire [W-1:0] level
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // ----------------------------------------------------------------------
  // Stages, reset to ones since idle bus lines float high
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      sync_q <= {W{1'b1}};
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  assign level = sync_q;
endmodule // vicd_sync

/* File: vicd_prio.v */
// Combinational priority picker over eight bits with a movable lowest position.
// Assumes base names the lowest-priority bit; base zero makes bit 7 highest.
`timescale 1ns/1ps
module vicd_prio (
  input wire [7:0] vec,
  input wire [2:0] base,
  output reg any,
  output reg [2:0] idx
);
  integer r;
  reg [2:0] pos;

  // ----------------------------------------------------------------------
  // Walk from lowest rank upward; the last hit is the highest rank
  // ----------------------------------------------------------------------
  always @* begin
    any = 1'b0;
    idx = 3'h0;
    pos = 3'h0;
    for (r = 0; r < 8; r = r + 1) begin
      pos = base + r[2:0];
      if (vec[pos]) begin
        any = 1'b1;
        idx = pos;
      end
    end
  end
endmodule // vicd_prio

/* File: vicd_decoder.v */
// Command decoder and register update logic of an eight-input interrupt controller.
// Assumes host strobes are one-cycle pulses on clk; request pins are asynchronous.
`timescale 1ns/1ps
`include "vicd_defs.vh"
module vicd_decoder (
  input wire clk,
  input wire rst,
  input wire ctl_wr,
  input wire ctl_rd,
  input wire dat_wr,
  input wire dat_rd,
  input wire [7:0] wr_data,
  output wire [7:0] rd_data,
  output wire rd_valid,
  input wire [7:0] req_pin,
  output wire int_pin,
  input wire ack,
  output wire [2:0] ack_vec,
  output wire ack_valid
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function [7:0] onehot;
    input [2:0] n;
    begin
      onehot = 8'h01 << n;
    end
  endfunction

  // Bits strictly above position n
  function [7:0] above;
    input [2:0] n;
    integer k;
    begin
      above = 8'h00;
      for (k = 0; k < 8; k = k + 1) begin
        if (k > n) begin
          above[k] = 1'b1;
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  reg [7:0] pending_request_reg_q;
  reg [7:0] pending_request_reg_d;
  reg [7:0] request_mask_reg_q;
  reg [7:0] request_mask_reg_d;
  reg [7:0] in_service_reg_q;
  reg [7:0] in_service_reg_d;
  reg [7:0] auto_clear_reg_q;
  reg [7:0] auto_clear_reg_d;
  reg [7:0] operating_options_q;
  reg [7:0] operating_options_d;
  reg [1:0] write_target_q;
  reg [1:0] write_target_d;
  reg [2:0] lowest_pos_q;
  reg [2:0] lowest_pos_d;
  reg [7:0] active_prev_q;
  reg [7:0] rd_data_q;
  reg rd_valid_q;
  reg int_pin_q;
  reg [2:0] ack_vec_q;
  reg ack_valid_q;

  reg [7:0] pend_set;
  reg [7:0] pend_clr;
  reg [7:0] srv_set;
  reg [7:0] srv_clr;
  reg do_reset;

  // ----------------------------------------------------------------------
  // Option fields
  // ----------------------------------------------------------------------
  wire rotating_priority_sel = operating_options_q[`VICD_M_ROT];
  wire common_vector_sel = operating_options_q[`VICD_M_COMMON];
  wire polled_sel = operating_options_q[`VICD_M_POLLED];
  wire output_polarity_sel = operating_options_q[`VICD_M_OUTPOL];
  wire input_polarity_sel = operating_options_q[`VICD_M_INPOL];
  wire read_select_low = operating_options_q[`VICD_M_RDLO];
  wire read_select_high = operating_options_q[`VICD_M_RDHI];
  wire arm_bit = operating_options_q[`VICD_M_ARM];

  // ----------------------------------------------------------------------
  // Command fields
  // ----------------------------------------------------------------------
  wire [4:0] op5 = wr_data[7:3];
  wire [3:0] op4 = wr_data[7:4];
  wire [2:0] bit_index_field = wr_data[2:0];
  wire [7:0] index_bit = onehot(bit_index_field);
  wire arm_ctl_high = wr_data[1];
  wire arm_ctl_low = wr_data[0];

  // ----------------------------------------------------------------------
  // Request lines: synchronise, apply sense, catch the activating edge
  // ----------------------------------------------------------------------
  wire [7:0] req_level;

  vicd_sync #(
    .W(8)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin(req_pin),
    .level(req_level)
  );

  // Only edges latch, so a line held active after a clear needs to toggle again
  wire [7:0] req_active = input_polarity_sel ? req_level : ~req_level;
  wire [7:0] req_rise = req_active & ~active_prev_q;

  // ----------------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------------
  wire [2:0] base = rotating_priority_sel ? lowest_pos_q : 3'h0;
  wire [7:0] unmasked = pending_request_reg_q & ~request_mask_reg_q;
  wire req_any;
  wire [2:0] req_idx;
  wire srv_any;
  wire [2:0] srv_idx;
  wire elig_any;
  wire [2:0] elig_idx;

  vicd_prio u_req_prio (
    .vec(unmasked),
    .base(base),
    .any(req_any),
    .idx(req_idx)
  );

  vicd_prio u_srv_prio (
    .vec(in_service_reg_q),
    .base(base),
    .any(srv_any),
    .idx(srv_idx)
  );

  // Rotating mode never nests: any service bit holds everything off
  wire [7:0] fence = !srv_any ? `VICD_ONES8 :
                     rotating_priority_sel ? `VICD_ZERO8 : above(srv_idx);
  wire [7:0] eligible = unmasked & fence & {8{arm_bit}};

  vicd_prio u_elig_prio (
    .vec(eligible),
    .base(base),
    .any(elig_any),
    .idx(elig_idx)
  );

  wire group_out = elig_any & ~polled_sel;
  wire take_ack = ack & group_out;
  wire status_grp = req_any & arm_bit;

  // ----------------------------------------------------------------------
  // Next-state: acknowledge, data write, command
  // ----------------------------------------------------------------------
  always @* begin
    pend_set = req_rise;
    pend_clr = 8'h00;
    srv_set = 8'h00;
    srv_clr = 8'h00;
    do_reset = 1'b0;
    request_mask_reg_d = request_mask_reg_q;
    auto_clear_reg_d = auto_clear_reg_q;
    operating_options_d = operating_options_q;
    write_target_d = write_target_q;
    lowest_pos_d = lowest_pos_q;

    // Acknowledge moves the winner into service unless it self-clears
    if (take_ack) begin
      pend_clr = onehot(elig_idx);
      srv_set = onehot(elig_idx) & ~auto_clear_reg_q;
      lowest_pos_d = elig_idx;
    end

    // Data port write consumes the one-shot target; reads leave it alone
    if (dat_wr) begin
      case (write_target_q)
        `VICD_WT_MASK: request_mask_reg_d = wr_data;
        `VICD_WT_ACLR: auto_clear_reg_d = wr_data;
        default: ;
      endcase
      write_target_d = `VICD_WT_NONE;
    end

    if (ctl_wr) begin
      if (wr_data == `VICD_CMD_RESET) begin
        do_reset = 1'b1;
      end else if (op4 == `VICD_OP4_CLR_TOP_SRV) begin
        // Picks by current priority, which may not be the intended bit
        srv_clr = srv_any ? onehot(srv_idx) : 8'h00;
      end else if (wr_data[7]) begin
        case (op4)
          `VICD_OP4_MODE_LOW_A, `VICD_OP4_MODE_LOW_B: begin
            operating_options_d[4:0] = wr_data[4:0];
          end
          `VICD_OP4_MODE_HIGH: begin
            operating_options_d[`VICD_M_RDHI] = wr_data[3];
            operating_options_d[`VICD_M_RDLO] = wr_data[2];
            case ({arm_ctl_high, arm_ctl_low})
              `VICD_ARM_SET: operating_options_d[`VICD_M_ARM] = 1'b1;
              `VICD_ARM_CLR: operating_options_d[`VICD_M_ARM] = 1'b0;
              default: ;
            endcase
          end
          `VICD_OP4_WSEL_MASK: write_target_d = `VICD_WT_MASK;
          `VICD_OP4_WSEL_ACLR: write_target_d = `VICD_WT_ACLR;
          default: ;
        endcase
      end else begin
        case (op5)
          `VICD_OP5_CLR_REQ_MSK: begin
            pend_clr = `VICD_ONES8;
            request_mask_reg_d = `VICD_ZERO8;
          end
          `VICD_OP5_CLR_ONE_REQ_MSK: begin
            pend_clr = pend_clr | index_bit;
            request_mask_reg_d = request_mask_reg_q & ~index_bit;
          end
          `VICD_OP5_CLR_MSK: request_mask_reg_d = `VICD_ZERO8;
          `VICD_OP5_CLR_ONE_MSK: request_mask_reg_d = request_mask_reg_q & ~index_bit;
          `VICD_OP5_SET_MSK: request_mask_reg_d = `VICD_ONES8;
          `VICD_OP5_SET_ONE_MSK: request_mask_reg_d = request_mask_reg_q | index_bit;
          `VICD_OP5_CLR_REQ: pend_clr = `VICD_ONES8;
          `VICD_OP5_CLR_ONE_REQ: pend_clr = pend_clr | index_bit;
          `VICD_OP5_SET_REQ: pend_set = `VICD_ONES8;
          `VICD_OP5_SET_ONE_REQ: pend_set = pend_set | index_bit;
          `VICD_OP5_CLR_SRV: srv_clr = `VICD_ONES8;
          `VICD_OP5_CLR_ONE_SRV: srv_clr = index_bit;
          default: ;
        endcase
      end
    end

    // New edges and acknowledges win over a clear in the same cycle
    pending_request_reg_d = (pending_request_reg_q & ~pend_clr) | pend_set;
    in_service_reg_d = (in_service_reg_q & ~srv_clr) | srv_set;

    if (do_reset) begin
      operating_options_d = `VICD_MODE_RST;
      write_target_d = `VICD_WT_NONE;
      lowest_pos_d = 3'h0;
      request_mask_reg_d = `VICD_MASK_RST;
      auto_clear_reg_d = `VICD_ZERO8;
      pending_request_reg_d = `VICD_ZERO8;
      in_service_reg_d = `VICD_ZERO8;
    end
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [7:0] status_word = {status_grp, 1'b0, rotating_priority_sel, polled_sel,
                            arm_bit, ~req_idx};
  reg [7:0] data_word;

  always @* begin
    case ({read_select_high, read_select_low})
      `VICD_RD_REQ: data_word = pending_request_reg_q;
      `VICD_RD_SRV: data_word = in_service_reg_q;
      `VICD_RD_MSK: data_word = request_mask_reg_q;
      `VICD_RD_ACLR: data_word = auto_clear_reg_q;
      default: data_word = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      pending_request_reg_q <= `VICD_ZERO8;
      request_mask_reg_q <= `VICD_MASK_RST;
      in_service_reg_q <= `VICD_ZERO8;
      auto_clear_reg_q <= `VICD_ZERO8;
      operating_options_q <= `VICD_MODE_RST;
      write_target_q <= `VICD_WT_NONE;
      lowest_pos_q <= 3'h0;
      active_prev_q <= `VICD_ONES8;
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
      int_pin_q <= 1'b1;
      ack_vec_q <= 3'h0;
      ack_valid_q <= 1'b0;
    end else begin
      pending_request_reg_q <= pending_request_reg_d;
      request_mask_reg_q <= request_mask_reg_d;
      in_service_reg_q <= in_service_reg_d;
      auto_clear_reg_q <= auto_clear_reg_d;
      operating_options_q <= operating_options_d;
      write_target_q <= write_target_d;
      lowest_pos_q <= lowest_pos_d;
      active_prev_q <= req_active;
      rd_valid_q <= ctl_rd | dat_rd;
      if (ctl_rd) begin
        rd_data_q <= status_word;
      end else if (dat_rd) begin
        rd_data_q <= data_word;
      end
      int_pin_q <= output_polarity_sel ? group_out : ~group_out;
      ack_valid_q <= take_ack;
      if (take_ack) begin
        ack_vec_q <= common_vector_sel ? `VICD_COMMON_VEC : elig_idx;
      end
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign int_pin = int_pin_q;
  assign ack_vec = ack_vec_q;
  assign ack_valid = ack_valid_q;
endmodule // vicd_decoder

/* File: vicd_decoder_assertions.sv */
// Port-level checks of the interrupt command decoder.
// Assumes host strobes last one cycle and reset is synchronous on clk.
`timescale 1ns/1ps
module vicd_decoder_assertions (
  input wire clk,
  input wire rst,
  input wire ctl_wr,
  input wire ctl_rd,
  input wire dat_rd,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire rd_valid,
  input wire int_pin,
  input wire ack,
  input wire ack_valid
);
  // --------------------------------------------------------------------
  // Read port timing and status word contents
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_read_gets_answer: assert property ((ctl_rd || dat_rd) |=> rd_valid)
    else $error("read strobe without answer");
  a_valid_needs_read: assert property ((!ctl_rd && !dat_rd) |=> !rd_valid)
    else $error("answer without read strobe");
  a_status_spare_zero: assert property (ctl_rd |=> rd_data[6] == 1'b0)
    else $error("status bit six not zero");
  a_status_needs_arm: assert property (ctl_rd |=> (!rd_data[7] || rd_data[3]))
    else $error("group interrupt flagged while disarmed");
  a_data_only_read: assert property (!$stable(rd_data) |-> rd_valid)
    else $error("read data changed outside a read");

  // --------------------------------------------------------------------
  // Interrupt output and acknowledge taking after commands
  // --------------------------------------------------------------------
  // Reset command also returns the output sense to active low, so idle is high
  a_reset_cmd_idle: assert property ((ctl_wr && wr_data == 8'h00) ##1 !ctl_wr |=> int_pin)
    else $error("interrupt active after reset command");
  a_mask_all_quiet: assert property ((ctl_wr && wr_data == 8'h30) ##1 (!ctl_wr) [*2]
    |=> $stable(int_pin))
    else $error("interrupt moved while all masked");
  a_masked_no_take: assert property ((ctl_wr && wr_data == 8'h30) ##1 (!ctl_wr && !ack)
    ##1 (ack && !ctl_wr) |=> !ack_valid)
    else $error("acknowledge taken while all masked");
  a_disarm_no_take: assert property ((ctl_wr && wr_data[7:4] == 4'ha && wr_data[1:0] == 2'h2)
    ##1 (!ctl_wr && !ack) ##1 (ack && !ctl_wr) |=> !ack_valid)
    else $error("acknowledge taken while disarmed");

  c_taken: cover property (ack_valid);
  c_group_status: cover property (ctl_rd ##1 (rd_valid && rd_data[7]));
  c_reset_cmd: cover property (ctl_wr && wr_data == 8'h00);
endmodule // vicd_decoder_assertions

bind vicd_decoder vicd_decoder_assertions u_vicd_decoder_assertions (
  .clk(clk), .rst(rst), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .dat_rd(dat_rd),
  .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid), .int_pin(int_pin),
  .ack(ack), .ack_valid(ack_valid));

/* File: vicd_host.sv */
// Host processor model: one-cycle strobes on the control and data ports.
// Assumes a top module named testbench that owns the mismatch count.
`timescale 1ns/1ps
module vicd_host (
  input wire clk,
  input wire [7:0] rd_data,
  input wire rd_valid,
  output reg ctl_wr,
  output reg ctl_rd,
  output reg dat_wr,
  output reg dat_rd,
  output reg [7:0] wr_data
);
  // --------------------------------------------------------------------
  // Port cycles
  // --------------------------------------------------------------------
  initial begin
    ctl_wr = 1'b0;
    ctl_rd = 1'b0;
    dat_wr = 1'b0;
    dat_rd = 1'b0;
    wr_data = 8'h00;
  end

  // Arm field 11 only goes out when the bench asks for it on purpose
  task put(input logic is_dat, input logic [7:0] val);
    begin
      @(posedge clk);
      wr_data <= val;
      if (is_dat) dat_wr <= 1'b1;
      else ctl_wr <= 1'b1;
      @(posedge clk);
      ctl_wr <= 1'b0;
      dat_wr <= 1'b0;
    end
  endtask

  // Answer comes one cycle after the strobe; bounded so a dead port ends the run
  task get(input logic is_dat, output logic [7:0] val);
    integer i;
    logic got;
    begin
      got = 1'b0;
      val = 8'h00;
      @(posedge clk);
      if (is_dat) dat_rd <= 1'b1;
      else ctl_rd <= 1'b1;
      @(posedge clk);
      ctl_rd <= 1'b0;
      dat_rd <= 1'b0;
      for (i = 0; i < 4 && !got; i = i + 1) begin
        @(negedge clk);
        if (rd_valid === 1'b1) begin
          val = rd_data;
          got = 1'b1;
        end
      end
      if (!got) begin
        testbench.fails = testbench.fails + 1;
        testbench.stop_test();
      end
    end
  endtask
endmodule // vicd_host

/* File: testbench.sv */
// Directed test of the interrupt command decoder through its host ports.
// Assumes request lines idle high and the host model in vicd_host.sv.
`timescale 1ns/1ps
module testbench;
  reg clk;
  reg rst;
  reg [7:0] req_pin;
  reg ack;
  wire ctl_wr, ctl_rd, dat_wr, dat_rd, rd_valid, int_pin, ack_valid;
  wire [7:0] wr_data;
  wire [7:0] rd_data;
  wire [2:0] ack_vec;
  integer fails;
  integer samples_checked;
  logic [7:0] v;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  vicd_decoder u_vicd_decoder (.clk(clk), .rst(rst), .ctl_wr(ctl_wr), .ctl_rd(ctl_rd),
    .dat_wr(dat_wr), .dat_rd(dat_rd), .wr_data(wr_data), .rd_data(rd_data),
    .rd_valid(rd_valid), .req_pin(req_pin), .int_pin(int_pin), .ack(ack),
    .ack_vec(ack_vec), .ack_valid(ack_valid));
  vicd_host u_vicd_host (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .dat_wr(dat_wr), .dat_rd(dat_rd), .wr_data(wr_data));

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task stop_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask

  task cmd(input logic [7:0] c);
    u_vicd_host.put(1'b0, c);
  endtask

  // Preselect keeps the arm bit, so reading never disturbs arming
  task chk_reg(input string name, input logic [1:0] sel, input logic [7:0] exp);
    begin
      cmd({4'ha, sel, 2'h0});
      u_vicd_host.get(1'b1, v);
      check(name, v, exp);
    end
  endtask

  task chk_st(input logic [7:0] exp, input logic [7:0] keep);
    begin
      u_vicd_host.get(1'b0, v);
      check("status", v & keep, exp);
    end
  endtask

  task wait_int(input logic lvl);
    integer i;
    begin
      for (i = 0; i < 20 && int_pin !== lvl; i = i + 1) @(negedge clk);
      check("int_pin", {7'h00, int_pin}, {7'h00, lvl});
      if (int_pin !== lvl) stop_test();
    end
  endtask

  task do_ack(input logic ev, input logic [2:0] evec);
    begin
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(negedge clk);
      check("ack_valid", {7'h00, ack_valid}, {7'h00, ev});
      if (ev) check("ack_vec", {5'h00, ack_vec}, {5'h00, evec});
    end
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req_pin = 8'hff;
    ack = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cmd(8'h5b);
    u_vicd_host.get(1'b1, v);
    check("service_preselected", v, 8'h00);
    chk_reg("pending", 2'h0, 8'h08);
    cmd(8'h40);
    chk_reg("pending", 2'h0, 8'h00);
    chk_reg("mask", 2'h2, 8'hff);
    chk_reg("autoclear", 2'h3, 8'h00);
    chk_st(8'h00, 8'hb8);
    check("int_idle", {7'h00, int_pin}, 8'h01);
    cmd(8'h50);
    chk_reg("pending", 2'h0, 8'hff);
    cmd(8'h20);
    chk_reg("mask", 2'h2, 8'h00);
    chk_st(8'h00, 8'h88);
    check("int_disarmed", {7'h00, int_pin}, 8'h01);
    cmd(8'ha1);
    chk_st(8'h88, 8'hff);
    wait_int(1'b0);
    cmd(8'h3f);
    chk_reg("mask", 2'h2, 8'h80);
    chk_st(8'h89, 8'hff);
    cmd(8'h4e);
    chk_reg("pending", 2'h0, 8'hbf);
    chk_st(8'h8a, 8'hff);
    cmd(8'h30);
    do_ack(1'b0, 3'h0);
    wait_int(1'b1);
    chk_reg("mask", 2'h2, 8'hff);
    cmd(8'h2d);
    chk_reg("mask", 2'h2, 8'hdf);
    cmd(8'h1a);
    chk_reg("mask", 2'h2, 8'hdb);
    chk_reg("pending", 2'h0, 8'hbb);
    cmd(8'h10);
    chk_reg("pending", 2'h0, 8'h00);
    chk_reg("mask", 2'h2, 8'h00);
    cmd(8'h38);
    chk_reg("mask", 2'h2, 8'h01);
    // Target write with a data read in between, then a stray write that must drop
    cmd(8'hb0);
    u_vicd_host.get(1'b1, v);
    u_vicd_host.put(1'b1, 8'h5a);
    u_vicd_host.put(1'b1, 8'h33);
    chk_reg("mask", 2'h2, 8'h5a);
    cmd(8'hc0);
    u_vicd_host.put(1'b1, 8'h0f);
    chk_reg("autoclear", 2'h3, 8'h0f);
    chk_reg("mask", 2'h2, 8'h5a);
    cmd(8'h85);
    chk_st(8'h38, 8'h78);
    u_vicd_host.get(1'b1, v);
    check("preselect_kept", v, 8'h5a);
    cmd(8'h80);
    cmd(8'ha6);
    chk_st(8'h00, 8'h08);
    cmd(8'ha1);
    cmd(8'hab);
    chk_st(8'h08, 8'h08);
    u_vicd_host.get(1'b1, v);
    check("illegal_arm_preselect", v, 8'h5a);
    cmd(8'ha2);
    do_ack(1'b0, 3'h0);
    cmd(8'ha0);
    chk_st(8'h00, 8'h08);
    // Service path: line 2 from the pins, line 7 from the set command
    cmd(8'hc0);
    u_vicd_host.put(1'b1, 8'h01);
    cmd(8'h20);
    cmd(8'ha1);
    @(posedge clk);
    req_pin <= 8'hfb;
    wait_int(1'b0);
    do_ack(1'b1, 3'h2);
    chk_reg("service", 2'h1, 8'h04);
    cmd(8'h5f);
    wait_int(1'b0);
    do_ack(1'b1, 3'h7);
    chk_reg("service", 2'h1, 8'h84);
    cmd(8'h60);
    chk_reg("service", 2'h1, 8'h04);
    cmd(8'h5f);
    wait_int(1'b0);
    do_ack(1'b1, 3'h7);
    cmd(8'h7a);
    chk_reg("service", 2'h1, 8'h80);
    cmd(8'h70);
    chk_reg("service", 2'h1, 8'h00);
    cmd(8'h40);
    chk_reg("pending", 2'h0, 8'h00);
    cmd(8'h5f);
    wait_int(1'b0);
    do_ack(1'b1, 3'h7);
    cmd(8'h5b);
    // Active-high output sense first, so the reset command must visibly restore active low
    cmd(8'h88);
    wait_int(1'b0);
    cmd(8'h00);
    u_vicd_host.get(1'b1, v);
    check("service_after_reset", v, 8'h00);
    chk_reg("pending", 2'h0, 8'h00);
    chk_reg("mask", 2'h2, 8'hff);
    chk_reg("autoclear", 2'h3, 8'h00);
    chk_st(8'h00, 8'hb8);
    check("int_after_reset", {7'h00, int_pin}, 8'h01);
    req_pin <= 8'hff;
    stop_test();
  end
endmodule // testbench
